// *** sim/iopd_host.sv ***
// Purpose: register host issuing single-word accesses
// Assumes: strobes pulse for one cycle per word
// Notes: an idle bus shows inverted last values, never stale ones
`timescale 1ns/1ps
`default_nettype none
module iopd_host (
	input wire logic clk_in,
	output logic wr_out,
	output logic rd_out,
	output iopd_pkg::iopd_ptr_t ptr_out,
	output iopd_pkg::iopd_word_t wdata_out,
	input wire iopd_pkg::iopd_word_t rdata_in,
	input wire logic ack_in,
	input wire logic err_in
);
	import iopd_pkg::*;
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		ptr_out = 4'hF;
		wdata_out = 16'hFFFF;
	end
	task automatic access(input logic wr, input iopd_ptr_t p,
		input iopd_word_t wd, output iopd_word_t rd, output logic ack,
		output logic err);
		@(posedge clk_in);
		wr_out <= wr;
		rd_out <= ~wr;
		ptr_out <= p;
		wdata_out <= wd;
		@(posedge clk_in);
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		ptr_out <= ~p;
		wdata_out <= ~wd;
		@(posedge clk_in);
		rd = rdata_in;
		ack = ack_in;
		err = err_in;
	endtask : access
	// Write then read back on the next cycle, no idle gap between
	task automatic write_read(input iopd_ptr_t p, input iopd_word_t wd,
		output iopd_word_t rd, output logic ack_w, output logic ack_r);
		@(posedge clk_in);
		wr_out <= 1'b1;
		rd_out <= 1'b0;
		ptr_out <= p;
		wdata_out <= wd;
		@(posedge clk_in);
		wr_out <= 1'b0;
		rd_out <= 1'b1;
		@(posedge clk_in);
		ack_w = ack_in;
		rd_out <= 1'b0;
		ptr_out <= ~p;
		wdata_out <= ~wd;
		@(posedge clk_in);
		ack_r = ack_in;
		rd = rdata_in;
	endtask : write_read
endmodule : iopd_host
`default_nettype wire

// *** sim/iopd_top_tb.sv ***
// Purpose: self-checking bench for the pin configuration block
// Assumes: pointers 0..2 mapped, pins settle one cycle after a write
// Notes: expected values are worked out by hand from the pin mapping
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin \
	err_count++; $display("mismatch at %0t: value differs", $time); end end
module iopd_top_tb;
	import iopd_pkg::*;
	logic sys_clk_in, rst_in, wr, rd, ack, err;
	iopd_ptr_t ptr;
	iopd_word_t wdata, rdata;
	iopd_pins_t alt_out, alt_oe, pin_in, pin_out, pin_oe, gsel, gdata;
	int err_count, comparisons;
	iopd_top dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_ptr_in(ptr),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack),
		.reg_err_out(err), .alt_out_in(alt_out), .alt_oe_in(alt_oe),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe),
		.gp_in_sel_out(gsel), .gp_in_data_out(gdata));
	iopd_host host_u (.clk_in(sys_clk_in), .wr_out(wr), .rd_out(rd),
		.ptr_out(ptr), .wdata_out(wdata), .rdata_in(rdata),
		.ack_in(ack), .err_in(err));
	task automatic tally_and_finish;
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	// One access; read data is compared only on reads
	task automatic acc(input logic w, input iopd_ptr_t p,
		input iopd_word_t d, input logic exp_err);
		iopd_word_t got;
		logic a, e;
		host_u.access(w, p, d, got, a, e);
		`CHK(a, 1'b1)
		`CHK(e, exp_err)
		if (!w) begin
			`CHK(got, d)
		end
	endtask : acc
	task automatic pins(input iopd_pins_t oe, input iopd_pins_t lvl);
		@(posedge sys_clk_in);
		#1;
		`CHK(pin_oe, oe)
		`CHK(pin_out, lvl)
	endtask : pins
	task automatic wr_rd(input iopd_ptr_t p, input iopd_word_t d,
		input iopd_word_t exp);
		iopd_word_t got;
		logic aw, ar;
		host_u.write_read(p, d, got, aw, ar);
		`CHK(aw, 1'b1)
		`CHK(ar, 1'b1)
		`CHK(got, exp)
	endtask : wr_rd
	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (3000) @(posedge sys_clk_in);
		err_count++;
		tally_and_finish();
	end
	initial begin
		err_count = 0;
		comparisons = 0;
		rst_in = 1'b1;
		alt_out = 8'h5C;
		alt_oe = 8'h93;
		pin_in = 8'h6B;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			acc(1'b0, iopd_ptr_t'(i), 16'h0000, 1'b0);
		end
		acc(1'b1, 4'h1, 16'hFFAA, 1'b0);
		acc(1'b0, 4'h1, 16'h00AA, 1'b0);
		acc(1'b1, 4'h0, 16'hFF0F, 1'b0);
		pins(8'h9F, 8'h5A);
		// Both selects on pins 0..1: output keeps priority
		acc(1'b1, 4'h2, 16'h00F3, 1'b0);
		pins(8'h0F, 8'h0A);
		@(posedge sys_clk_in);
		#1;
		`CHK(gsel, 8'hF0)
		`CHK(gdata, 8'h60)
		acc(1'b1, 4'h0, 16'h00FF, 1'b0);
		acc(1'b1, 4'h1, 16'h0081, 1'b0);
		pins(8'hFF, 8'h81);
		@(posedge sys_clk_in);
		alt_out <= 8'hA3;
		alt_oe <= 8'h6C;
		acc(1'b1, 4'h0, 16'h0000, 1'b0);
		acc(1'b1, 4'h2, 16'h0000, 1'b0);
		pins(8'h6C, 8'hA3);
		wr_rd(4'h1, 16'h3C5A, 16'h005A);
		acc(1'b1, 4'h0, 16'h0081, 1'b0);
		acc(1'b1, 4'h2, 16'h0042, 1'b0);
		pins(8'hAD, 8'h20);
		`CHK(gdata, 8'h42)
		// Mid-run reset: pads drop at once, registers read back zero
		@(posedge sys_clk_in);
		rst_in <= 1'b1;
		pins(8'h00, 8'h00);
		@(posedge sys_clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			acc(1'b0, iopd_ptr_t'(i), 16'h0000, 1'b0);
		end
		pins(8'h6C, 8'hA3);
		acc(1'b1, 4'hF, 16'h00FF, 1'b1);
		acc(1'b0, 4'h3, 16'h0000, 1'b1);
		acc(1'b0, 4'h0, 16'h0000, 1'b0);
		tally_and_finish();
	end
endmodule : iopd_top_tb
`undef CHK
`default_nettype wire

// *** src/iopd_pin_mux.sv ***
// Purpose: resolve each pin's drive from the configuration bits
// Assumes: alternate function signals come from the rest of the device
// Notes: purely combinational; the top registers what leaves the chip
`timescale 1ns/1ps
`default_nettype none
module iopd_pin_mux (
	input wire iopd_pkg::iopd_pins_t out_sel_in,
	input wire iopd_pkg::iopd_pins_t out_level_in,
	input wire iopd_pkg::iopd_pins_t in_sel_in,
	input wire iopd_pkg::iopd_pins_t alt_out_in,
	input wire iopd_pkg::iopd_pins_t alt_oe_in,
	output logic [iopd_pkg::PIN_COUNT-1:0] pin_out_out,
	output logic [iopd_pkg::PIN_COUNT-1:0] pin_oe_out,
	output logic [iopd_pkg::PIN_COUNT-1:0] gp_in_out
);
	import iopd_pkg::*;

	// ----------------------------------------------------------------
	// Per-pin selection
	// ----------------------------------------------------------------
	// output select drives pin, bit n to pin n
	wire iopd_pins_t drive_gp = out_sel_in;
	// Output select wins over input select so a pin is never both
	// input select releases pin
	wire iopd_pins_t sense_gp = in_sel_in & ~out_sel_in;
	wire iopd_pins_t other_fn = ~(out_sel_in | sense_gp);

	assign pin_out_out = (drive_gp & out_level_in) | (other_fn & alt_out_in);
	assign pin_oe_out = drive_gp | (other_fn & alt_oe_in);
	assign gp_in_out = sense_gp;

endmodule : iopd_pin_mux
`default_nettype wire

// *** src/iopd_pkg.sv ***
// Purpose: constants for the digital pin configuration block
// Assumes: registers are reached over the device's I2C register port
// Notes: register pointers are local word indices, one register per index
//
// Contract
// - Output-select bit n at 1 makes pin n a general-purpose output.
// - Select bit at 0 leaves pin function to other configuration.
// - Output pin drives the level held in its output-level bit.
// - Input-select bit n at 1 makes pin n a general-purpose input; code: only while output-select bit n is 0.
// - All three reset to zero; bits 15..8 read-only zero; 7..0 R/W.
// - Register bit n maps directly onto I/O pin n.
`default_nettype none
package iopd_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PIN_COUNT = 8;
	localparam int REG_WIDTH = 16;
	localparam int PTR_WIDTH = 4;

	typedef logic [PIN_COUNT-1:0] iopd_pins_t;
	typedef logic [REG_WIDTH-1:0] iopd_word_t;
	typedef logic [PTR_WIDTH-1:0] iopd_ptr_t;

	// ----------------------------------------------------------------
	// Register pointers
	// ----------------------------------------------------------------
	localparam iopd_ptr_t PTR_OUTPUT_SELECT = 4'h0;
	localparam iopd_ptr_t PTR_OUTPUT_LEVEL = 4'h1;
	localparam iopd_ptr_t PTR_INPUT_SELECT = 4'h2;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int PIN_FIELD_LSB = 0;
	localparam int PIN_FIELD_MSB = 7;
	localparam iopd_pins_t PIN_RESET = 8'h00;
	localparam logic [7:0] RSVD_READ = 8'h00;
	localparam iopd_word_t WORD_ZERO = 16'h0000;

	// Pin function after resolution
	typedef enum logic [1:0] {
		IOPD_FN_OTHER,
		IOPD_FN_GP_OUT,
		IOPD_FN_GP_IN
	} iopd_fn_t;

	// Reserved upper byte always returns zero
	function automatic iopd_word_t iopd_pack(input iopd_pins_t v);
		iopd_pack = {RSVD_READ, v};
	endfunction : iopd_pack

endpackage : iopd_pkg
`default_nettype wire

// *** src/iopd_top.sv ***
// Purpose: GPIO output/input selection and output level registers
// Assumes: the I2C front end hands over decoded single-word accesses
// Notes: pin outputs lag the register write by one clock
`timescale 1ns/1ps
`default_nettype none
module iopd_top (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire iopd_pkg::iopd_ptr_t reg_ptr_in,
	input wire iopd_pkg::iopd_word_t reg_wdata_in,
	output iopd_pkg::iopd_word_t reg_rdata_out,
	output logic reg_ack_out,
	output logic reg_err_out,
	input wire iopd_pkg::iopd_pins_t alt_out_in,
	input wire iopd_pkg::iopd_pins_t alt_oe_in,
	input wire iopd_pkg::iopd_pins_t pin_in,
	output iopd_pkg::iopd_pins_t pin_out,
	output iopd_pkg::iopd_pins_t pin_oe_out,
	output iopd_pkg::iopd_pins_t gp_in_sel_out,
	output iopd_pkg::iopd_pins_t gp_in_data_out
);
	import iopd_pkg::*;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire hit_osel = (reg_ptr_in == PTR_OUTPUT_SELECT);
	wire hit_olvl = (reg_ptr_in == PTR_OUTPUT_LEVEL);
	wire hit_isel = (reg_ptr_in == PTR_INPUT_SELECT);
	wire hit_any = hit_osel | hit_olvl | hit_isel;
	wire access = reg_wr_in | reg_rd_in;
	wire wr_osel = reg_wr_in & hit_osel;
	wire wr_olvl = reg_wr_in & hit_olvl;
	wire wr_isel = reg_wr_in & hit_isel;
	wire iopd_pins_t wr_bits = reg_wdata_in[PIN_FIELD_MSB:PIN_FIELD_LSB];

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	iopd_pins_t out_sel_reg;
	iopd_pins_t out_sel_next;
	iopd_pins_t out_lvl_reg;
	iopd_pins_t out_lvl_next;
	iopd_pins_t in_sel_reg;
	iopd_pins_t in_sel_next;

	// low byte writable, upper byte dropped
	assign out_sel_next = wr_osel ? wr_bits : out_sel_reg;
	assign out_lvl_next = wr_olvl ? wr_bits : out_lvl_reg;
	assign in_sel_next = wr_isel ? wr_bits : in_sel_reg;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			out_sel_reg <= PIN_RESET;
			out_lvl_reg <= PIN_RESET;
			in_sel_reg <= PIN_RESET;
		end else begin
			out_sel_reg <= out_sel_next;
			out_lvl_reg <= out_lvl_next;
			in_sel_reg <= in_sel_next;
		end
	end

	// ----------------------------------------------------------------
	// Read path and answer
	// ----------------------------------------------------------------
	iopd_word_t rdata_reg;
	iopd_word_t rdata_next;
	logic ack_reg;
	logic err_reg;
	wire iopd_word_t rd_word =
		hit_osel ? iopd_pack(out_sel_reg) :
		hit_olvl ? iopd_pack(out_lvl_reg) :
		hit_isel ? iopd_pack(in_sel_reg) : WORD_ZERO;

	assign rdata_next = reg_rd_in ? rd_word : rdata_reg;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_reg <= WORD_ZERO;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			ack_reg <= access;
			err_reg <= access & ~hit_any;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign reg_ack_out = ack_reg;
	assign reg_err_out = err_reg;

	// ----------------------------------------------------------------
	// Pin resolution
	// ----------------------------------------------------------------
	iopd_pins_t mux_out;
	iopd_pins_t mux_oe;
	iopd_pins_t mux_in_sel;

	iopd_pin_mux u_mux (
		.out_sel_in(out_sel_reg),
		.out_level_in(out_lvl_reg),
		.in_sel_in(in_sel_reg),
		.alt_out_in(alt_out_in),
		.alt_oe_in(alt_oe_in),
		.pin_out_out(mux_out),
		.pin_oe_out(mux_oe),
		.gp_in_out(mux_in_sel)
	);

	iopd_pins_t pin_out_reg;
	iopd_pins_t pin_oe_reg;
	iopd_pins_t in_sel_out_reg;
	iopd_pins_t in_data_reg;

	// Registered so pad drive never glitches during a register update
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_out_reg <= PIN_RESET;
			pin_oe_reg <= PIN_RESET;
			in_sel_out_reg <= PIN_RESET;
			in_data_reg <= PIN_RESET;
		end else begin
			pin_out_reg <= mux_out;
			pin_oe_reg <= mux_oe;
			in_sel_out_reg <= mux_in_sel;
			in_data_reg <= pin_in & mux_in_sel;
		end
	end

	assign pin_out = pin_out_reg;
	assign pin_oe_out = pin_oe_reg;
	assign gp_in_sel_out = in_sel_out_reg;
	assign gp_in_data_out = in_data_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_osel_drives_pin: assert property (
		(reg_wr_in && hit_osel) |-> ##2
		((pin_oe_out & $past(wr_bits, 2)) == $past(wr_bits, 2)))
		else $error("output select did not enable pin drive");

	// Pads stay in reset at the release edge, so skip that edge
	a_other_follows_alt: assert property (
		(!rst_in && out_sel_reg == PIN_RESET && in_sel_reg == PIN_RESET)
		|=> (pin_oe_out == $past(alt_oe_in) && pin_out == $past(alt_out_in)))
		else $error("unselected pin did not follow other function");

	a_level_on_pin: assert property (
		1'b1 |=> ((pin_out & $past(out_sel_reg)) ==
		($past(out_lvl_reg) & $past(out_sel_reg))))
		else $error("output pin level differs from level register");

	a_isel_releases_pin: assert property (
		1'b1 |=> ((pin_oe_out & $past(in_sel_reg) & ~$past(out_sel_reg))
		== PIN_RESET
		&& gp_in_sel_out == ($past(in_sel_reg) & ~$past(out_sel_reg))))
		else $error("input pin still driven or not flagged");

	a_rsvd_read_zero: assert property (
		reg_rd_in |=> (reg_rdata_out[REG_WIDTH-1:PIN_FIELD_MSB+1] == RSVD_READ
		&& reg_ack_out))
		else $error("reserved bits read nonzero");

	a_readback_write: assert property (
		(reg_wr_in && !reg_rd_in && hit_olvl) ##1 (reg_rd_in && hit_olvl
		&& !reg_wr_in) |=> (reg_rdata_out == iopd_pack($past(wr_bits, 2))))
		else $error("written level did not read back");

	a_bit_to_pin: assert property (
		(out_sel_reg[0] && !out_sel_reg[PIN_COUNT-1])
		|=> (pin_oe_out[0] && pin_out[0] == $past(out_lvl_reg[0])))
		else $error("bit zero did not control pin zero");

	a_unmapped_err: assert property (
		(access && !hit_any) |=> (reg_err_out && reg_ack_out))
		else $error("unmapped access not flagged");

	// First edge after release: all state still at its reset value
	a_reset_clears: assert property (
		$fell(rst_in) |-> (out_sel_reg == PIN_RESET
		&& out_lvl_reg == PIN_RESET && in_sel_reg == PIN_RESET
		&& pin_oe_out == PIN_RESET && pin_out == PIN_RESET
		&& reg_rdata_out == WORD_ZERO && !reg_ack_out))
		else $error("state not cleared by reset");

	a_isel_out_low: assert property (
		1'b1 |=> ((pin_out & $past(in_sel_reg) & ~$past(out_sel_reg))
		== PIN_RESET))
		else $error("input pin drives a level");

	a_osel_store: assert property (
		wr_osel |=> (out_sel_reg == $past(wr_bits)))
		else $error("output select write not stored");

	a_ack_only_access: assert property (
		!access |=> !reg_ack_out)
		else $error("answer without a request");

	a_mapped_no_err: assert property (
		(access && hit_any) |=> !reg_err_out)
		else $error("error flagged on a mapped register");

	a_rdata_holds: assert property (
		!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data changed without a read");

	c_write_level: cover property (wr_olvl ##2 (pin_oe_out != PIN_RESET));
	c_input_mode: cover property (wr_isel ##2 (gp_in_sel_out != PIN_RESET));
	c_read_back: cover property ((reg_rd_in && hit_osel) ##1 reg_ack_out);
	c_unmapped: cover property (access && !hit_any);
	c_write_read: cover property (wr_olvl ##1 (reg_rd_in && hit_olvl));

endmodule : iopd_top
`default_nettype wire
